// ==== logic/acr_channel_regs.sv ====
// Channel-one configuration register bank with decoded path settings
`timescale 1ns/10ps
`default_nettype none
module acr_channel_regs
  import acr_pkg::*;
(
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  // Register access from the control port
  input  wire logic [7:0]  REG_PAGE,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  output logic             REG_RVALID,
  output logic             REG_HIT,
  // Global autogain enable from the shared setup register
  input  wire logic        AUTOGAIN_GLOBAL_SETUP,
  // Input path settings
  output logic             CH_A_INPUT_KIND,
  output acr_src_t         CH_A_INPUT_SOURCE,
  output logic             CH_A_ANALOG_PATH,
  output logic             CH_A_PDM_PATH,
  output logic             CH_A_COUPLING_SELECT,
  output logic      [1:0]  CH_A_INPUT_IMPEDANCE,
  output logic             CH_A_SETUP_RESERVED,
  output logic             CH_A_AUTOGAIN_ACTIVE,
  // Levels
  output logic      [5:0]  CH_A_ANALOG_GAIN,
  output logic             CH_A_GAIN_RESERVED,
  output logic             CH_A_MUTE,
  output logic signed [8:0] CH_A_VOLUME_HALF_DB,
  output logic signed [3:0] CH_A_GAIN_TRIM_TENTH_DB,
  output logic      [7:0]  CH_A_PHASE_TRIM
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [7:0] input_setup_q;
  logic [7:0] gain_q;
  logic [7:0] volume_q;
  logic [7:0] gain_trim_q;
  logic [7:0] phase_trim_q;
  logic       page_ok;
  logic       sel_setup;
  logic       sel_gain;
  logic       sel_volume;
  logic       sel_trim;
  logic       sel_phase;
  logic [7:0] rdata_d;

  // One select per register; other pages never alias onto this bank
  assign page_ok    = (REG_PAGE == ACR_PAGE_ZERO);
  assign sel_setup  = page_ok && (REG_ADDR == ACR_OFS_INPUT_SETUP);
  assign sel_gain   = page_ok && (REG_ADDR == ACR_OFS_GAIN);
  assign sel_volume = page_ok && (REG_ADDR == ACR_OFS_VOLUME);
  assign sel_trim   = page_ok && (REG_ADDR == ACR_OFS_GAIN_TRIM);
  assign sel_phase  = page_ok && (REG_ADDR == ACR_OFS_PHASE_TRIM);
  assign REG_HIT    = sel_setup | sel_gain | sel_volume | sel_trim | sel_phase;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------

  // Input setup: reserved bit 1 is masked on write
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      input_setup_q <= ACR_RST_INPUT_SETUP;
    end else if (REG_WR && sel_setup) begin
      input_setup_q <= REG_WDATA & ACR_MASK_INPUT_SETUP;
    end
  end

  // Analog gain: low two bits reserved
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      gain_q <= ACR_RST_GAIN;
    end else if (REG_WR && sel_gain) begin
      gain_q <= REG_WDATA & ACR_MASK_GAIN;
    end
  end

  // Digital volume comes up at unity so audio passes without setup
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      volume_q <= ACR_RST_VOLUME;
    end else if (REG_WR && sel_volume) begin
      volume_q <= REG_WDATA;
    end
  end

  // Gain trim: low nibble reserved
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      gain_trim_q <= ACR_RST_GAIN_TRIM;
    end else if (REG_WR && sel_trim) begin
      gain_trim_q <= REG_WDATA & ACR_MASK_GAIN_TRIM;
    end
  end

  // Phase trim is stored whole; its delay is applied downstream
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      phase_trim_q <= ACR_RST_PHASE_TRIM;
    end else if (REG_WR && sel_phase) begin
      phase_trim_q <= REG_WDATA;
    end
  end

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------

  // Masked storage means reserved bits already read as zero
  always_comb begin
    rdata_d = 8'h00;
    case (1'b1)
      sel_setup:  rdata_d = input_setup_q;
      sel_gain:   rdata_d = gain_q;
      sel_volume: rdata_d = volume_q;
      sel_trim:   rdata_d = gain_trim_q;
      sel_phase:  rdata_d = phase_trim_q;
      default:    rdata_d = 8'h00;
    endcase
  end

  // Read data is held until the next read; unmapped reads give zero
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Input path settings
  // ----------------------------------------------------------------
  acr_src_t src;

  assign src                  = acr_src_t'(input_setup_q[ACR_POS_SRC +: 2]);
  assign CH_A_INPUT_KIND      = input_setup_q[ACR_POS_KIND];
  assign CH_A_INPUT_SOURCE    = src;
  // Reserved source drives neither path, so nothing is connected by accident
  assign CH_A_ANALOG_PATH     = (src == ACR_SRC_ANALOG_DIFF) ||
                                (src == ACR_SRC_ANALOG_SE);
  assign CH_A_PDM_PATH        = (src == ACR_SRC_PDM);
  // Coupling and impedance only mean something on an analog path
  assign CH_A_COUPLING_SELECT = CH_A_ANALOG_PATH &
                                input_setup_q[ACR_POS_COUPLING];
  assign CH_A_INPUT_IMPEDANCE = CH_A_ANALOG_PATH ?
                                input_setup_q[ACR_POS_IMP +: 2] : 2'h0;
  assign CH_A_SETUP_RESERVED  = (src == ACR_SRC_RESERVED) ||
                                (input_setup_q[ACR_POS_IMP +: 2] == ACR_IMP_RESERVED);
  assign CH_A_AUTOGAIN_ACTIVE = input_setup_q[ACR_POS_AUTOGAIN] &
                                AUTOGAIN_GLOBAL_SETUP;
  assign CH_A_PHASE_TRIM      = phase_trim_q;

  // ----------------------------------------------------------------
  // Level decode
  // ----------------------------------------------------------------
  acr_cfg_if cfg ();

  assign cfg.gain_code = gain_q[ACR_POS_GAIN +: 6];
  assign cfg.vol_code  = volume_q;
  assign cfg.trim_code = gain_trim_q[ACR_POS_TRIM +: 4];

  acr_level_decode u_decode (
    .clk   (CORE_CLK),
    .rst_n (RESETN),
    .cfg   (cfg)
  );

  assign CH_A_ANALOG_GAIN        = cfg.gain_db;
  assign CH_A_GAIN_RESERVED      = cfg.gain_reserved;
  assign CH_A_MUTE               = cfg.vol_mute;
  assign CH_A_VOLUME_HALF_DB     = cfg.vol_half_db;
  assign CH_A_GAIN_TRIM_TENTH_DB = cfg.trim_tenth_db;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_write(logic sel);
    REG_WR && sel;
  endsequence

  property p_kind;
    @(posedge CORE_CLK) disable iff (!RESETN)
      s_write(sel_setup) |=> (CH_A_INPUT_KIND == $past(REG_WDATA[7]));
  endproperty
  a_kind: assert property (p_kind) else $error("input kind not taken from bit 7");

  property p_pdm;
    @(posedge CORE_CLK) disable iff (!RESETN)
      s_write(sel_setup) ##1 (!REG_WR) |->
        (CH_A_PDM_PATH == ($past(REG_WDATA[6:5]) == 2'h2)) &&
        !(CH_A_PDM_PATH && CH_A_ANALOG_PATH);
  endproperty
  a_pdm: assert property (p_pdm) else $error("source field decode wrong");

  property p_coupling;
    @(posedge CORE_CLK) disable iff (!RESETN)
      !CH_A_ANALOG_PATH |-> (CH_A_COUPLING_SELECT == 1'b0) && (CH_A_INPUT_IMPEDANCE == 2'h0);
  endproperty
  a_coupling: assert property (p_coupling) else $error("setting on non-analog path");

  property p_autogain;
    @(posedge CORE_CLK) disable iff (!RESETN)
      !AUTOGAIN_GLOBAL_SETUP || !input_setup_q[0] |-> !CH_A_AUTOGAIN_ACTIVE;
  endproperty
  a_autogain: assert property (p_autogain) else $error("autogain on while disabled");

  property p_gain;
    @(posedge CORE_CLK) disable iff (!RESETN)
      s_write(sel_gain) ##1 1'b1 ##1 1'b1 |->
        (CH_A_ANALOG_GAIN <= ACR_GAIN_MAX_DB) &&
        (CH_A_GAIN_RESERVED == ($past(REG_WDATA[7:2], 2) > ACR_GAIN_MAX_DB));
  endproperty
  a_gain: assert property (p_gain) else $error("gain decode wrong");

  property p_mute;
    @(posedge CORE_CLK) disable iff (!RESETN)
      s_write(sel_volume) ##1 !(REG_WR && sel_volume) |=>
        (CH_A_MUTE == ($past(REG_WDATA, 2) == 8'h00));
  endproperty
  a_mute: assert property (p_mute) else $error("mute not tied to volume code zero");

  property p_vol_reset;
    @(posedge CORE_CLK) $rose(RESETN) |-> (volume_q == 8'hc9) && (REG_RDATA == 8'h00);
  endproperty
  a_vol_reset: assert property (p_vol_reset) else $error("volume not unity at reset");

  property p_trim;
    @(posedge CORE_CLK) disable iff (!RESETN)
      s_write(sel_trim) ##1 1'b1 |=>
        (CH_A_GAIN_TRIM_TENTH_DB == $signed({1'b0, $past(REG_WDATA[7:4], 2)} - 5'sd8));
  endproperty
  a_trim: assert property (p_trim) else $error("gain trim not code minus eight");

  property p_reserved_read;
    @(posedge CORE_CLK) disable iff (!RESETN)
      REG_RD && !REG_HIT |=> REG_RVALID && (REG_RDATA == 8'h00);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("bad unmapped read");

  property p_mask;
    @(posedge CORE_CLK) disable iff (!RESETN)
      (gain_q[1:0] == 2'h0) && (gain_trim_q[3:0] == 4'h0) && (input_setup_q[1] == 1'b0);
  endproperty
  a_mask: assert property (p_mask) else $error("reserved bit was stored");

  // Reads return the stored byte; a read beside a write still sees the old value
  sequence s_read(logic sel);
    REG_RD && sel;
  endsequence

  property p_read_gain;
    @(posedge CORE_CLK) disable iff (!RESETN)
      s_read(sel_gain) |=> REG_RVALID && (REG_RDATA == $past(gain_q)) &&
                           (REG_RDATA[1:0] == 2'h0);
  endproperty
  a_read_gain: assert property (p_read_gain) else $error("gain readback wrong");

  // On an analog path the stored coupling and impedance reach the front end
  property p_impedance;
    @(posedge CORE_CLK) disable iff (!RESETN)
      CH_A_ANALOG_PATH |-> (CH_A_INPUT_IMPEDANCE == input_setup_q[3:2]) &&
                           (CH_A_COUPLING_SELECT == input_setup_q[4]);
  endproperty
  a_impedance: assert property (p_impedance) else $error("analog setting not passed");

  // Volume level lands two edges after the write, in half-dB steps from unity
  property p_volume_level;
    @(posedge CORE_CLK) disable iff (!RESETN)
      s_write(sel_volume) ##1 !(REG_WR && sel_volume) |=>
        (CH_A_VOLUME_HALF_DB == $signed({1'b0, $past(REG_WDATA, 2)} - 9'sd201));
  endproperty
  a_volume_level: assert property (p_volume_level) else $error("volume level wrong");

  // Gain write followed by the decoder's extra register stage
  sequence s_gain_settled;
    s_write(sel_gain) ##1 1'b1 ##1 1'b1;
  endsequence

  property p_gain_step;
    @(posedge CORE_CLK) disable iff (!RESETN)
      s_gain_settled |-> (CH_A_ANALOG_GAIN ==
        (($past(REG_WDATA[7:2], 2) > 6'd42) ? 6'd42 : $past(REG_WDATA[7:2], 2)));
  endproperty
  a_gain_step: assert property (p_gain_step) else $error("applied gain wrong");

  // Writable setup bits land whole; the reserved bit stays clear
  property p_setup_write;
    @(posedge CORE_CLK) disable iff (!RESETN)
      s_write(sel_setup) |=> (input_setup_q[7:2] == $past(REG_WDATA[7:2])) &&
                             (input_setup_q[0] == $past(REG_WDATA[0])) && !input_setup_q[1];
  endproperty
  a_setup_write: assert property (p_setup_write) else $error("setup write lost");

  // Trim comes out of reset at its mid code, which applies no correction
  property p_trim_reset;
    @(posedge CORE_CLK)
      $rose(RESETN) |-> (gain_trim_q == 8'h80) && (CH_A_GAIN_TRIM_TENTH_DB == 4'sh0);
  endproperty
  a_trim_reset: assert property (p_trim_reset) else $error("trim not 0 dB at reset");

endmodule
`default_nettype wire

// ==== logic/acr_pkg.sv ====
// Package: constants and types for the channel-one configuration register bank
package acr_pkg;

  // ----------------------------------------------------------------
  // Register map, page zero
  // ----------------------------------------------------------------
  localparam logic [7:0] ACR_PAGE_ZERO        = 8'h00;
  localparam logic [7:0] ACR_OFS_INPUT_SETUP  = 8'h3c;
  localparam logic [7:0] ACR_OFS_GAIN         = 8'h3d;
  localparam logic [7:0] ACR_OFS_VOLUME       = 8'h3e;
  localparam logic [7:0] ACR_OFS_GAIN_TRIM    = 8'h3f;
  localparam logic [7:0] ACR_OFS_PHASE_TRIM   = 8'h40;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACR_POS_KIND     = 7;
  localparam int ACR_POS_SRC      = 5;
  localparam int ACR_POS_COUPLING = 4;
  localparam int ACR_POS_IMP      = 2;
  localparam int ACR_POS_AUTOGAIN = 0;
  localparam int ACR_POS_GAIN     = 2;
  localparam int ACR_POS_TRIM     = 4;

  // Writable bits per register; the rest are reserved
  localparam logic [7:0] ACR_MASK_INPUT_SETUP = 8'hfd;
  localparam logic [7:0] ACR_MASK_GAIN        = 8'hfc;
  localparam logic [7:0] ACR_MASK_GAIN_TRIM   = 8'hf0;

  // ----------------------------------------------------------------
  // Reset values and code points
  // ----------------------------------------------------------------
  localparam logic [7:0] ACR_RST_INPUT_SETUP = 8'h00;
  localparam logic [7:0] ACR_RST_GAIN        = 8'h00;
  localparam logic [7:0] ACR_RST_VOLUME      = 8'hc9;
  localparam logic [7:0] ACR_RST_GAIN_TRIM   = 8'h80;
  localparam logic [7:0] ACR_RST_PHASE_TRIM  = 8'h00;
  localparam logic [5:0] ACR_GAIN_MAX_DB     = 6'h2a;
  localparam logic [7:0] ACR_VOL_MUTE        = 8'h00;
  localparam logic [8:0] ACR_VOL_UNITY       = 9'h0c9;
  localparam logic [1:0] ACR_IMP_RESERVED    = 2'h3;

  // Input source selection
  typedef enum logic [1:0] {
    ACR_SRC_ANALOG_DIFF = 2'h0,
    ACR_SRC_ANALOG_SE   = 2'h1,
    ACR_SRC_PDM         = 2'h2,
    ACR_SRC_RESERVED    = 2'h3
  } acr_src_t;

endpackage

// ==== logic/acr_cfg_if.sv ====
// Interface: level codes from the register bank and their decoded values
`timescale 1ns/10ps
`default_nettype none
interface acr_cfg_if;
  logic [5:0]        gain_code;
  logic [7:0]        vol_code;
  logic [3:0]        trim_code;
  logic [5:0]        gain_db;
  logic              gain_reserved;
  logic              vol_mute;
  logic signed [8:0] vol_half_db;
  logic signed [3:0] trim_tenth_db;

  modport regs   (output gain_code, vol_code, trim_code,
                  input  gain_db, gain_reserved, vol_mute, vol_half_db, trim_tenth_db);
  modport decode (input  gain_code, vol_code, trim_code,
                  output gain_db, gain_reserved, vol_mute, vol_half_db, trim_tenth_db);
endinterface
`default_nettype wire

// ==== logic/acr_level_decode.sv ====
// Level decoder: turns gain, volume and trim codes into applied levels
`timescale 1ns/10ps
`default_nettype none
module acr_level_decode
  import acr_pkg::*;
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Codes in, levels out
  acr_cfg_if.decode   cfg
);

  // ----------------------------------------------------------------
  // Registered level decode
  // ----------------------------------------------------------------

  // Reserved gain codes saturate at the top step rather than wrap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.gain_db       <= 6'h00;
      cfg.gain_reserved <= 1'b0;
    end else begin
      cfg.gain_reserved <= (cfg.gain_code > ACR_GAIN_MAX_DB);
      cfg.gain_db       <= (cfg.gain_code > ACR_GAIN_MAX_DB) ?
                           ACR_GAIN_MAX_DB : cfg.gain_code;
    end
  end

  // Volume in half-dB steps relative to unity; code zero mutes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.vol_mute    <= 1'b0;
      cfg.vol_half_db <= 9'sh000;
    end else begin
      cfg.vol_mute    <= (cfg.vol_code == ACR_VOL_MUTE);
      cfg.vol_half_db <= $signed({1'b0, cfg.vol_code} - ACR_VOL_UNITY);
    end
  end

  // Code minus eight is the code with its top bit inverted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.trim_tenth_db <= 4'sh0;
    end else begin
      cfg.trim_tenth_db <= $signed({~cfg.trim_code[3], cfg.trim_code[2:0]});
    end
  end

endmodule
`default_nettype wire

// ==== tb/acr_host_model.sv ====
// Host model: control-port master that writes and reads the register bank
`timescale 1ns/10ps
`default_nettype none
module acr_host_model (
  // Clock
  input  wire logic       clk,
  // Request side
  output logic      [7:0] page,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  // Answer side
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  // Pins claimed by the PDM microphone, else free for analog use
  logic pdm_pins;

  // Idle bus at time zero
  initial begin
    page = 8'h00;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    pdm_pins = 1'b0;
  end

  // ------------------------------------------------------------
  // Bus cycles, launched on the falling edge; gap models a slow host
  // ------------------------------------------------------------
  task automatic send_write(input logic [7:0] p, a, d, input int gap);
    repeat (gap) @(negedge clk);
    @(negedge clk);
    page = p;
    addr = a;
    wdata = d;
    wr = 1'b1;
    // Pins are set up before the source change lands
    if (p == 8'h00 && a == 8'h3c) pdm_pins = (d[6:5] == 2'h2);
    @(negedge clk);
    wr = 1'b0;
    wdata = ~d; // Stale data is not left on the bus
  endtask

  task automatic send_read(input logic [7:0] p, a, input int gap,
                           output logic [7:0] d, output logic v);
    repeat (gap) @(negedge clk);
    @(negedge clk);
    page = p;
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    d = rdata;
    v = rvalid;
    rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/acr_channel_regs_tb.sv ====
// Testbench: random and corner register traffic against the channel-one bank
`timescale 1ns/10ps
`default_nettype none
module acr_channel_regs_tb;
  import acr_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  typedef struct packed {
    logic kind; logic [1:0] src; logic an, pdm, cpl; logic [1:0] imp;
    logic sres, ag_on; logic [5:0] gain; logic gres, mute; logic [8:0] half;
    logic [3:0] trim;
  } acr_exp_t;
  logic              clk, rst_n, glob, wr, rd, rvalid, hit;
  logic [7:0]        page, addr, wdata, rdata, phase;
  logic              kind, an, pdm, cpl, sres, ag_on, gres, mute;
  acr_src_t          src;
  logic [1:0]        imp;
  logic [5:0]        gain;
  logic signed [8:0] half;
  logic signed [3:0] trim;
  logic [7:0]        regs [0:4];
  int                errors = 0;
  int                n_compared = 0;
  localparam logic [15:0] CORNERS [19] = '{16'h3e00, 16'h3e01, 16'h3ec9, 16'h3eff,
    16'h3da8, 16'h3dac, 16'h3dff, 16'h3f00, 16'h3f0f, 16'h3fff, 16'h3c00, 16'h3c20,
    16'h3c40, 16'h3c60, 16'h3cff, 16'h3c9d, 16'h3c0d, 16'h4055, 16'h40ff};

  // Free-running core clock, 100 MHz
  always #5 clk = ~clk;

  acr_channel_regs u_acr_channel_regs (
    .CORE_CLK(clk), .RESETN(rst_n), .REG_PAGE(page), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .REG_HIT(hit), .AUTOGAIN_GLOBAL_SETUP(glob),
    .CH_A_INPUT_KIND(kind), .CH_A_INPUT_SOURCE(src), .CH_A_ANALOG_PATH(an),
    .CH_A_PDM_PATH(pdm), .CH_A_COUPLING_SELECT(cpl), .CH_A_INPUT_IMPEDANCE(imp),
    .CH_A_SETUP_RESERVED(sres), .CH_A_AUTOGAIN_ACTIVE(ag_on),
    .CH_A_ANALOG_GAIN(gain), .CH_A_GAIN_RESERVED(gres), .CH_A_MUTE(mute),
    .CH_A_VOLUME_HALF_DB(half), .CH_A_GAIN_TRIM_TENTH_DB(trim),
    .CH_A_PHASE_TRIM(phase));

  acr_host_model u_acr_host_model (.clk(clk), .page(page), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rvalid(rvalid));

  // ------------------------------------------------------------
  // Expectations and comparison
  // ------------------------------------------------------------
  function automatic logic [7:0] wmask(int i);
    case (i)
      0: return 8'hfd;
      1: return 8'hfc;
      3: return 8'hf0;
      default: return 8'hff;
    endcase
  endfunction

  function automatic acr_exp_t expect_levels(logic [7:0] s, g, v, t, logic gl);
    acr_exp_t e;
    e.kind = s[7];
    e.src = s[6:5];
    e.an = (s[6:5] < 2'h2);
    e.pdm = (s[6:5] == 2'h2);
    e.cpl = e.an & s[4];
    e.imp = e.an ? s[3:2] : 2'h0;
    e.sres = (s[6:5] == 2'h3) || (s[3:2] == 2'h3);
    e.ag_on = s[0] & gl;
    e.gain = (g[7:2] > 6'h2a) ? 6'h2a : g[7:2]; // Saturates above the top code
    e.gres = (g[7:2] > 6'h2a);
    e.mute = (v == 8'h00);
    e.half = {1'b0, v} - 9'h0c9;
    e.trim = t[7:4] - 4'h8;
    return e;
  endfunction

  task automatic chk(string what, logic [8:0] seen, logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_all();
    acr_exp_t e;
    e = expect_levels(regs[0], regs[1], regs[2], regs[3], glob);
    chk("kind", 9'(kind), 9'(e.kind));
    chk("source", 9'(src), 9'(e.src));
    chk("analog", 9'(an), 9'(e.an));
    chk("pdm", 9'(pdm), 9'(e.pdm));
    chk("coupling", 9'(cpl), 9'(e.cpl));
    chk("impedance", 9'(imp), 9'(e.imp));
    chk("setup_rsvd", 9'(sres), 9'(e.sres));
    chk("autogain", 9'(ag_on), 9'(e.ag_on));
    chk("gain", 9'(gain), 9'(e.gain));
    chk("gain_rsvd", 9'(gres), 9'(e.gres));
    chk("mute", 9'(mute), 9'(e.mute));
    chk("half_db", $unsigned(half), e.half);
    chk("trim", 9'($unsigned(trim)), 9'(e.trim));
    chk("phase", 9'(phase), 9'(regs[4]));
  endtask

  // Optional write, then read back and compare every output
  task automatic do_op(logic [7:0] p, a, d, logic we);
    logic [7:0] q;
    logic v, h;
    int i;
    h = (p == 8'h00) && (a >= 8'h3c) && (a <= 8'h40);
    i = int'(a) - 8'h3c;
    @(negedge clk);
    glob = 1'($urandom_range(1));
    if (we) u_acr_host_model.send_write(p, a, d, $urandom_range(2));
    if (we && h) regs[i] = d & wmask(i);
    u_acr_host_model.send_read(p, a, $urandom_range(2), q, v);
    chk("rvalid", 9'(v), 9'h001);
    chk("hit", 9'(hit), 9'(h));
    chk("rdata", 9'(q), h ? 9'(regs[i]) : 9'h000);
    @(negedge clk);
    check_all();
    // The host's pin claim must agree with the source the bank decodes
    chk("pdm_pins", 9'(pdm), 9'(u_acr_host_model.pdm_pins));
  endtask

  task automatic final_report();
    $display("Compared %0d values, %0d mismatches", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("CHECK FAILED watchdog expected done seen running");
    final_report();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] q;
    logic v;
    clk = 1'b0;
    rst_n = 1'b0;
    glob = 1'b0;
    void'($urandom(32'h8a8d5eb3));
    regs = '{8'h00, 8'h00, 8'hc9, 8'h80, 8'h00};
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    check_all();
    u_acr_host_model.send_read(8'h00, 8'h3e, 0, q, v);
    chk("vol_reset", 9'(q), 9'h0c9);
    for (int a = 8'h3a; a <= 8'h42; a++) do_op(8'h00, 8'(a), 8'h00, 1'b0);
    do_op(8'h01, 8'h3e, 8'h00, 1'b0);
    $display("Test reset values done");
    foreach (CORNERS[k]) do_op(8'h00, CORNERS[k][15:8], CORNERS[k][7:0], 1'b1);
    $display("Test corner codes done");
    // Wrong page and neighbouring addresses must leave the bank untouched
    repeat (80) do_op(($urandom_range(7) == 0) ? 8'h01 : 8'h00,
                      8'h3a + 8'($urandom_range(8)), 8'($urandom), 1'b1);
    $display("Test random traffic done");
    // Reset in mid-run must bring every register back to its reset value
    @(negedge clk);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    regs = '{8'h00, 8'h00, 8'hc9, 8'h80, 8'h00};
    check_all();
    u_acr_host_model.send_read(8'h00, 8'h3e, 0, q, v);
    chk("vol_rereset", 9'(q), 9'h0c9);
    chk("rvalid", 9'(v), 9'h001);
    $display("Test mid-run reset done");
    final_report();
  end
endmodule
`default_nettype wire
